// *** rtl/ctrl_slave_pkg.sv ***
package ctrl_slave_pkg;
  // Bus address byte, direction bit included
  localparam logic [7:0] DEV_ADDR = 8'hDE;
  // Target select bit and payload width of a data byte
  localparam int SEL_BIT = 7;
  localparam int PAY_W = 7;
  // Mode register fields
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_MUTE_BIT = 1;
  localparam logic RUN_RST = 1'b0;
  localparam logic MUTE_RST = 1'b0;
  // Volume register field
  localparam int GAIN_W = 6;
  localparam logic [5:0] GAIN_RST = 6'h00;
  // Bits per byte on the link
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // Fastest serial clock and derived least half period at CLK rate
  localparam int SCL_MAX_KHZ = 400;
  localparam int CLK_KHZ = 25000;
  localparam int SCL_HALF_CYC = CLK_KHZ / (2 * SCL_MAX_KHZ);
endpackage

// *** rtl/ctrl_slave.sv ***
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// RULE_01: Serial clock up to 400 kHz supported.
// RULE_02: Master keeps data stable while clock high.
// RULE_03: Slave only; clock input, data open-drain.
// RULE_04: Transactions framed by START and STOP.
// RULE_05: Eight-bit bytes, each followed by acknowledge.
// RULE_06: Respond only to address byte 11011110.
// RULE_07: Master sends address MSB first, write.
// RULE_08: Read direction gets no acknowledge.
// RULE_09: Address bits captured on rising clock edge.
// RULE_10: Matching address acknowledged low on ninth pulse.
// RULE_11: Master sends data after seeing acknowledge.
// RULE_12: Top bit picks mode or volume register.
// RULE_13: Every data byte acknowledged.
// RULE_14: Any number of data bytes per frame.
// RULE_15: Master ends frame with STOP.
// RULE_16: START is data falling while clock high.
// RULE_17: Two write-only registers, nothing readable.
// RULE_18: START or STOP mid-byte drops partial byte.
// RULE_19: After STOP ignore bus until addressed.
// RULE_20: Mode bits run and mute, reset zero.
// RULE_21: Six-bit gain code, reset zero.
// RULE_22: Reserved payload bits ignored.
module ctrl_slave (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SCL,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_N,
  output logic POWER_DOWN_SELECT,
  output logic MUTE,
  output logic [ctrl_slave_pkg::GAIN_W-1:0] GAIN_CODE,
  output logic BUSY
);
  import ctrl_slave_pkg::*;

  // Refuse a system clock too slow to oversample the link
  if (SCL_HALF_CYC < 4) begin : g_clk_check // RULE_01
    $error("Clock too slow for serial link");
  end

  typedef enum logic [1:0] {
    IDLE = 2'b00,
    ADDR = 2'b01,
    DATA = 2'b10,
    IGNORE = 2'b11
  } state_e;

  state_e state;
  state_e next_state;
  logic scl_m;
  logic scl_s;
  logic scl_d;
  logic sda_m;
  logic sda_s;
  logic sda_d;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic ack;
  logic pend;
  logic ninth;
  logic run;
  logic mute;
  logic [GAIN_W-1:0] gain;

  // Two-flop synchronisers, then edge detect on second stage
  always_ff @(posedge CLK) begin
    scl_m <= SCL;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= SDA_IN;
    sda_s <= sda_m;
    sda_d <= sda_s;
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_ev = scl_s & scl_d & sda_d & ~sda_s; // RULE_16
  wire stop_ev = scl_s & scl_d & ~sda_d & sda_s; // RULE_04
  wire in_byte = (state == ADDR) || (state == DATA);
  wire byte_done = scl_rise && in_byte && (bit_cnt == BYTE_BITS - 4'h1); // RULE_05
  wire [7:0] full_byte = {shift[6:0], sda_s};
  wire addr_hit = (full_byte == DEV_ADDR); // RULE_06 RULE_08
  wire ack_slot = (bit_cnt == BYTE_BITS);
  wire ack_open = scl_fall && ack_slot && !ninth;
  wire ack_end = scl_fall && ack_slot && ninth;
  wire data_wr = byte_done && (state == DATA) && !ack_slot;
  wire sel_vol = full_byte[SEL_BIT]; // RULE_12

  always_comb begin
    next_state = state;
    if (start_ev) begin
      next_state = ADDR; // RULE_18
    end else if (stop_ev) begin
      next_state = IDLE; // RULE_18 RULE_19
    end else if (ack_end) begin
      case (state)
        ADDR: next_state = pend ? DATA : IGNORE;
        DATA: next_state = DATA; // RULE_14
        default: next_state = state;
      endcase
    end else if (byte_done && state == ADDR && !addr_hit) begin
      next_state = IGNORE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state <= IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter and shifter; ninth pulse is the acknowledge slot
  always_ff @(posedge CLK) begin
    if (RST || start_ev || stop_ev) begin
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      ninth <= 1'b0;
    end else if (ack_end) begin
      bit_cnt <= 4'h0;
      ninth <= 1'b0;
    end else if (ack_open) begin
      ninth <= 1'b1;
    end else if (scl_rise && in_byte && !ack_slot) begin
      shift <= full_byte; // RULE_09
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // Acknowledge decided on eighth rise, driven from the following fall to end of ninth
  always_ff @(posedge CLK) begin
    if (RST || start_ev || stop_ev || ack_end) begin
      pend <= 1'b0;
      ack <= 1'b0;
    end else if (byte_done) begin
      pend <= (state == DATA) || addr_hit; // RULE_10 RULE_13
    end else if (ack_open) begin
      ack <= pend; // RULE_10
    end
  end

  wire drive_low = ack_open ? pend : (ack && !ack_end);

  always_ff @(posedge CLK) begin
    if (RST) begin
      run <= RUN_RST;
      mute <= MUTE_RST;
      gain <= GAIN_RST;
    end else if (data_wr && !sel_vol) begin
      run <= full_byte[MODE_RUN_BIT]; // RULE_20 RULE_22
      mute <= full_byte[MODE_MUTE_BIT]; // RULE_20
    end else if (data_wr && sel_vol) begin
      gain <= full_byte[GAIN_W-1:0]; // RULE_21 RULE_22 RULE_17
    end
  end

  // Drive low only, never the clock
  always_ff @(posedge CLK) begin
    if (RST) begin
      SDA_OE_N <= 1'b1;
    end else begin
      SDA_OE_N <= ~drive_low; // RULE_03 RULE_10
    end
  end

  assign SDA_OUT = 1'b0; // RULE_03
  assign POWER_DOWN_SELECT = run;
  assign MUTE = mute;
  assign GAIN_CODE = gain;
  assign BUSY = (state == DATA);

endmodule // ctrl_slave

`default_nettype wire

// *** testbench/ctrl_slave_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctrl_slave_properties (
  input wire logic CLK,
  input wire logic RST,
  input wire logic SDA_OUT,
  input wire logic SDA_OE_N,
  input wire logic [5:0] GAIN_CODE,
  input wire logic MUTE,
  input wire logic POWER_DOWN_SELECT,
  input wire logic BUSY
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  a_sda_low: assert property (!SDA_OUT) else $error("sda");
  a_reset_clear:
    assert property (disable iff (1'b0) RST |=> SDA_OE_N && !BUSY && !GAIN_CODE)
      else $error("reset");
  a_ack_hold: assert property ($fell(SDA_OE_N) |=> !SDA_OE_N [*4]) else $error("ack");
  a_ack_end: assert property ($fell(SDA_OE_N) |-> ##[1:16] SDA_OE_N) else $error("ack");
  a_gap_idle: assert property ($rose(SDA_OE_N) |=> SDA_OE_N [*8]) else $error("gap");
  a_gain_busy: assert property ($changed(GAIN_CODE) |-> BUSY) else $error("gain");
  a_gain_hold:
    assert property ($changed(GAIN_CODE) |=> $stable(GAIN_CODE) [*8]) else $error("gain");
  a_write_first: assert property ($changed(GAIN_CODE) |-> SDA_OE_N) else $error("gain");
  a_mode_busy:
    assert property ($changed({MUTE, POWER_DOWN_SELECT}) |-> BUSY && SDA_OE_N) else $error("mode");
endmodule // ctrl_slave_properties
bind ctrl_slave ctrl_slave_properties u_props (.*);
`default_nettype wire

// *** testbench/bus_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module bus_master (
  input wire logic CLK,
  input wire logic SDA,
  output logic SCL = 1'b1,
  output logic SDA_DRV = 1'b1
);
  task automatic half;
    repeat (4) @(posedge CLK);
  endtask
  task automatic cond(input logic b);
    @(posedge CLK) SDA_DRV <= b;
    half;
    SCL <= 1'b1;
    half;
    SDA_DRV <= !b;
    half;
    SCL <= !b;
  endtask
  task automatic bit_io(input logic b, output logic s);
    @(posedge CLK) SDA_DRV <= b;
    repeat (3) @(posedge CLK);
    SCL <= 1'b1;
    half;
    s = SDA;
    SCL <= 1'b0;
  endtask
  task automatic send(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], ack);
    bit_io(1'b1, ack);
    ack = !ack;
  endtask
endmodule // bus_master
`default_nettype wire

// *** testbench/ctrl_slave_bench.sv ***
`timescale 1ns/100ps
`default_nettype none
module ctrl_slave_bench;
  import ctrl_slave_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic a;
  logic [7:0] st = 8'h00;
  logic [7:0] p = 8'h00;
  logic [7:0] d;
  logic [7:0] q[$];
  int errors = 0;
  int checked = 0;
  int seed = 32'h2715;
  wire logic SCL, m_sda, SDA_OUT, SDA_OE_N, POWER_DOWN_SELECT, MUTE, BUSY;
  wire logic [5:0] GAIN_CODE;
  wire logic SDA_IN = m_sda & (SDA_OE_N | SDA_OUT);
  wire logic [7:0] obs = {MUTE, POWER_DOWN_SELECT, GAIN_CODE};
  always #20 CLK = ~CLK;
  ctrl_slave u_ctrl_slave (.*);
  bus_master u_bus_master (.*, .SDA(SDA_IN), .SDA_DRV(m_sda));
  task automatic check(input string n, input logic [7:0] v, e);
    checked++;
    if (v !== e) begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, v);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(negedge CLK) begin
    if (!RST && obs !== p) begin
      check("regs", obs, q.size() ? q.pop_front() : p);
      p <= obs;
    end
  end
  task automatic frame(input logic [7:0] adr, input int n);
    logic hit;
    logic [7:0] e;
    hit = adr == DEV_ADDR;
    u_bus_master.cond(1'b1);
    u_bus_master.send(adr, a);
    check("addr ack", 8'(a), 8'(hit));
    repeat (n) begin
      d = 8'($random(seed));
      e = d[7] ? {st[7:6], d[5:0]} : {d[1:0], st[5:0]};
      if (hit && e !== st) q.push_back(e);
      st = hit ? e : st;
      u_bus_master.send(d, a);
      check("data ack", 8'(a), 8'(hit));
    end
    u_bus_master.cond(1'b0);
  endtask
  initial begin
    repeat (8) @(posedge CLK);
    RST <= 1'b0;
    repeat (4) @(posedge CLK);
    frame(DEV_ADDR, 4);
    frame(8'hDF, 2);
    u_bus_master.cond(1'b1);
    u_bus_master.send(DEV_ADDR, a);
    repeat (4) u_bus_master.bit_io(1'b1, a);
    u_bus_master.cond(1'b0);
    u_bus_master.send(DEV_ADDR, a);
    check("idle ack", 8'(a), 8'h00);
    frame(DEV_ADDR, 3);
    repeat (4) @(posedge CLK);
    check("pending", 8'(q.size()), 8'h00);
    summarize;
  end
endmodule // ctrl_slave_bench
`default_nettype wire
